/* core/stop_wake_defines.svh */
/*
  stop-mode wake-up control: offsets, field positions, reset values, timing.
  assumes inclusion by bare name from the design module and the bench.
*/
`ifndef STOP_WAKE_DEFINES_SVH
`define STOP_WAKE_DEFINES_SVH

`define ADDR_MODE     4'h0
`define ADDR_CTRL     4'h1
`define ADDR_CLKSEL   4'h2
`define ADDR_STATUS   4'h3
`define ADDR_CLKSEL_HI 4'h4
`define MODE_SAVE_SEL_BIT  0
`define CTRL_STOP_REQ_BIT  0
`define CTRL_PIN_NMI_MASK  1
`define CTRL_WDT_NMI_MASK  2
`define CTRL_MASKABLE_MASK 3
`define CTRL_RESET    8'h00
`define MODE_RESET    8'h00
`define CLKSEL_RESET  8'h00
`define CLKSEL_HI_RESET 8'h00
`define CLKSEL_SUB_USED    0
`define CLKSEL_UNIT1_TICK  1
`define CLKSEL_WATCH_SUB   2
`define CLKSEL_T8_EXT      3
`define CLKSEL_T8_MATCH    4
`define CLKSEL_TH1_SUB     5
`define CLKSEL_WDT2_SUB    6
`define CLKSEL_SER0_EXT    7
`define CLKSEL_HI_SER1_EXT 0
`define CLKSEL_HI_BAUD_EXT 1
`define OST_NS        1000
`define CLK_NS        100
`define OST_CYCLES    ((`OST_NS + `CLK_NS - 1) / `CLK_NS)

`endif

/* core/stop_wake_pkg.sv */
/*
  types for the stop-mode wake-up control.
  assumes the defines header sits beside it.
*/
package stop_wake_pkg;
  typedef enum logic [1:0] {st_run, st_stop, st_settle} stop_state_t;

  typedef struct packed {
    logic nmi_pin;
    logic nmi_wdt;
    logic mask_irq;
    logic [3:0] irq_prio;
  } wake_req_t;

  typedef struct packed {
    logic sub_used;
    logic unit1_watch_tick;
    logic watch_timer_sub;
    logic timer8_ext_input;
    logic timer8_unit1_match;
    logic timer_h_unit1_sub;
    logic wdt2_sub;
    logic serial_ch0_ext_clock;
    logic serial_ch1_ext_clock;
    logic uart_ext_baud_clock;
  } clk_sel_t;
endpackage : stop_wake_pkg

/* core/stop_wakeup_control.sv */
/*
  stop-mode wake-up controller: entry by software, release by interrupt or
  reset, acknowledge decision, and per-peripheral clock gating during stop.
  assumes wake requests are levels on clk, reset is the ordinary device reset.
*/
`timescale 1ns/1ps
`include "stop_wake_defines.svh"

module stop_wakeup_control
  import stop_wake_pkg::*;
#(
  parameter int OST_CYCLES = `OST_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire wake_req_t  req,
  input  wire logic       in_isr,
  input  wire logic [3:0] cur_prio,
  input  wire logic       irq_enabled_state,
  output logic            main_osc_en,
  output logic            sub_osc_en,
  output logic            core_clk_en,
  output logic            ack_q,
  output logic            branch_q,
  output logic            pending_q,
  output logic [9:0]      periph_run,
  output logic            stopped
);

  stop_state_t state_q, state_d;
  logic [7:0]  mode_q, mode_d, ctrl_q, ctrl_d, clksel_q, clksel_d;
  logic [7:0]  clksel_hi_q, clksel_hi_d;
  logic [7:0]  rdata_d;
  logic [15:0] ost_q, ost_d;
  logic        ack_d, branch_d, pend_d;
  logic        wake_nmi, wake_irq, wake, hi_prio;
  logic        main_d, sub_d, core_d, stopped_d;
  logic [9:0]  run_d;
  clk_sel_t    cs;

  // clock select fields, one register bit each
  always_comb begin
    cs.sub_used             = clksel_q[`CLKSEL_SUB_USED];
    cs.unit1_watch_tick     = clksel_q[`CLKSEL_UNIT1_TICK];
    cs.watch_timer_sub      = clksel_q[`CLKSEL_WATCH_SUB];
    cs.timer8_ext_input     = clksel_q[`CLKSEL_T8_EXT];
    cs.timer8_unit1_match   = clksel_q[`CLKSEL_T8_MATCH];
    cs.timer_h_unit1_sub    = clksel_q[`CLKSEL_TH1_SUB];
    cs.wdt2_sub             = clksel_q[`CLKSEL_WDT2_SUB];
    cs.serial_ch0_ext_clock = clksel_q[`CLKSEL_SER0_EXT];
    cs.serial_ch1_ext_clock = clksel_hi_q[`CLKSEL_HI_SER1_EXT];
    cs.uart_ext_baud_clock  = clksel_hi_q[`CLKSEL_HI_BAUD_EXT];
  end

  // wake sensing is pure combinational, no main clock needed
  always_comb begin
    wake_nmi = (req.nmi_pin & ~ctrl_q[`CTRL_PIN_NMI_MASK]) | (req.nmi_wdt & ~ctrl_q[`CTRL_WDT_NMI_MASK]);
    wake_irq = req.mask_irq & ~ctrl_q[`CTRL_MASKABLE_MASK];
    wake     = wake_nmi | wake_irq;
    hi_prio  = wake_nmi | ~in_isr | (req.irq_prio < cur_prio);
  end

  always_comb begin
    state_d   = state_q;
    mode_d    = mode_q;
    ctrl_d    = ctrl_q;
    clksel_d  = clksel_q;
    clksel_hi_d = clksel_hi_q;
    ost_d     = ost_q;
    ack_d     = 1'b0;
    branch_d  = 1'b0;
    pend_d    = pending_q;
    rdata_d   = 8'h00;
    if (wr && state_q == st_run) begin
      if (addr == `ADDR_MODE) begin
        mode_d = wdata;
      end else if (addr == `ADDR_CTRL) begin
        ctrl_d = wdata;
      end else if (addr == `ADDR_CLKSEL) begin
        clksel_d = wdata;
      end else if (addr == `ADDR_CLKSEL_HI) begin
        clksel_hi_d = wdata;
      end
    end
    if (rd) begin
      if (addr == `ADDR_MODE) begin
        rdata_d = mode_q;
      end else if (addr == `ADDR_CTRL) begin
        rdata_d = ctrl_q;
      end else if (addr == `ADDR_CLKSEL) begin
        rdata_d = clksel_q;
      end else if (addr == `ADDR_CLKSEL_HI) begin
        rdata_d = clksel_hi_q;
      end else if (addr == `ADDR_STATUS) begin
        rdata_d = {5'h00, pending_q, state_q};
      end
    end
    case (state_q)
      st_run: begin
        if (ctrl_q[`CTRL_STOP_REQ_BIT] && mode_q[`MODE_SAVE_SEL_BIT]) begin
          state_d = st_stop;
        end
      end
      st_stop: begin
        if (wake) begin
          state_d = st_settle;
          ost_d   = 16'(OST_CYCLES);
          ctrl_d[`CTRL_STOP_REQ_BIT] = 1'b0;
          if (hi_prio) begin
            ack_d    = 1'b1;
            branch_d = wake_nmi | irq_enabled_state;
          end else begin
            pend_d = 1'b1;
          end
        end
      end
      default: begin
        if (ost_q <= 16'h0001) begin
          state_d = st_run;
        end else begin
          ost_d = ost_q - 16'h0001;
        end
      end
    endcase
    if (ack_q) begin
      pend_d = 1'b0;
    end
    if (state_q == st_stop && wake && !hi_prio) begin
      pend_d = 1'b1;
    end
    main_d    = (state_d != st_stop);
    sub_d     = 1'b1;
    core_d    = (state_d == st_run);
    stopped_d = (state_d == st_stop);
    run_d[0]  = ~stopped_d | (cs.sub_used & cs.unit1_watch_tick & cs.watch_timer_sub);
    run_d[1]  = ~stopped_d | cs.timer8_ext_input | (cs.sub_used & cs.timer8_unit1_match & run_d[0]);
    run_d[2]  = ~stopped_d | (cs.sub_used & cs.timer_h_unit1_sub);
    run_d[3]  = ~stopped_d | (cs.sub_used & cs.watch_timer_sub);
    run_d[4]  = ~stopped_d | (cs.sub_used & cs.wdt2_sub);
    run_d[5]  = ~stopped_d | cs.serial_ch0_ext_clock;
    run_d[6]  = ~stopped_d | cs.serial_ch1_ext_clock;
    run_d[7]  = ~stopped_d | cs.uart_ext_baud_clock;
    run_d[8]  = ~stopped_d;
    run_d[9]  = ~stopped_d;
  end

  // ordinary reset, no stop-specific handling
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q     <= st_run;
      mode_q      <= `MODE_RESET;
      ctrl_q      <= `CTRL_RESET;
      clksel_q    <= `CLKSEL_RESET;
      clksel_hi_q <= `CLKSEL_HI_RESET;
      ost_q       <= 16'h0000;
      ack_q       <= 1'b0;
      branch_q    <= 1'b0;
      pending_q   <= 1'b0;
      rdata       <= 8'h00;
      main_osc_en <= 1'b1;
      sub_osc_en  <= 1'b1;
      core_clk_en <= 1'b1;
      stopped     <= 1'b0;
      periph_run  <= 10'h3ff;
    end else begin
      state_q     <= state_d;
      mode_q      <= mode_d;
      ctrl_q      <= ctrl_d;
      clksel_q    <= clksel_d;
      clksel_hi_q <= clksel_hi_d;
      ost_q       <= ost_d;
      ack_q       <= ack_d;
      branch_q    <= branch_d;
      pending_q   <= pend_d;
      rdata       <= rdata_d;
      main_osc_en <= main_d;
      sub_osc_en  <= sub_d;
      core_clk_en <= core_d;
      stopped     <= stopped_d;
      periph_run  <= run_d;
    end
  end

  property p_release;
    @(posedge clk) disable iff (rst) (state_q == st_stop && wake) |=> state_q == st_settle;
  endproperty
  a_release: assert property (p_release) else $error("stop not released");

  property p_low_no_ack;
    @(posedge clk) disable iff (rst) (state_q == st_stop && wake && !hi_prio) |=> !ack_q && pending_q;
  endproperty
  a_low_no_ack: assert property (p_low_no_ack) else $error("low priority acknowledged");

  property p_high_ack;
    @(posedge clk) disable iff (rst) (state_q == st_stop && wake && hi_prio) |=> ack_q;
  endproperty
  a_high_ack: assert property (p_high_ack) else $error("high priority not acknowledged");

  property p_nmi_branch;
    @(posedge clk) disable iff (rst) (state_q == st_stop && wake_nmi) |=> branch_q;
  endproperty
  a_nmi_branch: assert property (p_nmi_branch) else $error("nmi did not branch");

  property p_di_next;
    @(posedge clk) disable iff (rst) (state_q == st_stop && !wake_nmi && !irq_enabled_state) |=> !branch_q;
  endproperty
  a_di_next: assert property (p_di_next) else $error("branched while disabled");

  property p_masked;
    @(posedge clk) disable iff (rst) (state_q == st_stop && !wake) |=> state_q == st_stop;
  endproperty
  a_masked: assert property (p_masked) else $error("masked source released stop");

  property p_osc;
    @(posedge clk) disable iff (rst) (state_q == st_stop) |-> !main_osc_en && sub_osc_en && !core_clk_en;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator state wrong in stop");

  property p_settle;
    @(posedge clk) disable iff (rst) (state_q == st_stop && wake) |=> !core_clk_en [*1] ##0 (state_q == st_settle);
  endproperty
  a_settle: assert property (p_settle) else $error("resumed before stabilization");

  property p_entry;
    @(posedge clk) disable iff (rst) (state_q == st_run && !mode_q[`MODE_SAVE_SEL_BIT]) |=> state_q != st_stop;
  endproperty
  a_entry: assert property (p_entry) else $error("stop entered without mode select");

  // per-unit run enables around stop
  property p_run_all;
    @(posedge clk) disable iff (rst) (state_d != st_stop) |=> periph_run == 10'h3ff;
  endproperty
  a_run_all: assert property (p_run_all) else $error("unit held outside stop");

  property p_held_units;
    @(posedge clk) disable iff (rst) (state_d == st_stop) |=> periph_run[9:8] == 2'b00 && !core_clk_en;
  endproperty
  a_held_units: assert property (p_held_units) else $error("main clock unit running in stop");

  property p_unit1;
    @(posedge clk) disable iff (rst)
      (state_d == st_stop && !(cs.sub_used && cs.unit1_watch_tick && cs.watch_timer_sub)) |=> !periph_run[0];
  endproperty
  a_unit1: assert property (p_unit1) else $error("timer16 unit1 running without watch tick");

  property p_timer8;
    @(posedge clk) disable iff (rst) (state_d == st_stop && !cs.timer8_ext_input && !cs.sub_used) |=> !periph_run[1];
  endproperty
  a_timer8: assert property (p_timer8) else $error("8-bit timers running without clock source");

  property p_sub_units;
    @(posedge clk) disable iff (rst) (state_d == st_stop && !cs.sub_used) |=> periph_run[4:2] == 3'b000;
  endproperty
  a_sub_units: assert property (p_sub_units) else $error("subclock unit running without subclock");

  property p_serial;
    @(posedge clk) disable iff (rst) (state_d == st_stop && !cs.serial_ch0_ext_clock) |=> !periph_run[5];
  endproperty
  a_serial: assert property (p_serial) else $error("clocked serial running without shift clock");

  property p_baud;
    @(posedge clk) disable iff (rst) (state_d == st_stop && !cs.uart_ext_baud_clock) |=> !periph_run[7];
  endproperty
  a_baud: assert property (p_baud) else $error("async serial running without baud clock");

  property p_pend_hold;
    @(posedge clk) disable iff (rst) (pending_q && !ack_q) |=> pending_q;
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending request lost");

  property p_regs_hold;
    @(posedge clk) disable iff (rst)
      (state_q != st_run) |=> mode_q == $past(mode_q) && clksel_q == $past(clksel_q) && clksel_hi_q == $past(clksel_hi_q);
  endproperty
  a_regs_hold: assert property (p_regs_hold) else $error("register changed outside run");

  c_low: cover property (@(posedge clk) disable iff (rst) state_q == st_stop && wake && !hi_prio);
  c_nmi: cover property (@(posedge clk) disable iff (rst) state_q == st_stop && wake_nmi);
  c_back: cover property (@(posedge clk) disable iff (rst) state_q == st_settle ##1 state_q == st_run);
  c_di: cover property (@(posedge clk) disable iff (rst) state_q == st_stop && wake_irq && !irq_enabled_state);
  c_ext: cover property (@(posedge clk) disable iff (rst) stopped && periph_run[7]);

endmodule : stop_wakeup_control

/* bench/intc_model.sv */
/*
  cpu and interrupt controller stand-in holding the wake request levels.
  assumes the bench loads them; an acknowledge retires them.
*/
`timescale 1ns/1ps
module intc_model
  import stop_wake_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire logic      set_en,
  input  wire wake_req_t set_val,
  input  wire logic      ack_q,
  output wake_req_t      req
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      req <= '0;
    else if (ack_q)
      req <= '0;
    else if (set_en)
      req <= set_val;
  end
endmodule : intc_model

/* bench/tb_stop_wakeup_control.sv */
/*
  self-checking bench for the stop-mode wake-up control.
  assumes the design with a short stabilization count.
*/
`timescale 1ns/1ps
`include "stop_wake_defines.svh"
module tb_stop_wakeup_control
  import stop_wake_pkg::*;
;
  logic       clk = 0, rst = 1, wr = 0, rd = 0, in_isr = 0, irq_enabled_state = 1, set_en = 0;
  logic [3:0] addr = '0, cur_prio = '0;
  logic [7:0] wdata = '0, rdata;
  wake_req_t  req, set_val = '0;
  logic       main_osc_en, sub_osc_en, core_clk_en, ack_q, branch_q, pending_q, stopped;
  logic [9:0] periph_run;
  int         fail_count = 0, num_checks = 0;

  always #50 clk = ~clk;

  stop_wakeup_control #(.OST_CYCLES(2)) stop_wakeup_control_inst (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .req(req), .in_isr(in_isr), .cur_prio(cur_prio),
    .irq_enabled_state(irq_enabled_state), .main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en),
    .core_clk_en(core_clk_en), .ack_q(ack_q), .branch_q(branch_q), .pending_q(pending_q),
    .periph_run(periph_run), .stopped(stopped));
  intc_model intc_model_inst (.clk(clk), .rst(rst), .set_en(set_en), .set_val(set_val), .ack_q(ack_q),
    .req(req));

  task automatic chk(string what, logic [9:0] seen, logic [9:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(logic [3:0] a, logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", {2'b00, rdata}, {2'b00, exp});
  endtask : rd_chk

  task automatic setr(wake_req_t r);
    @(posedge clk);
    set_val <= r;
    set_en <= 1'b1;
    @(posedge clk);
    set_en <= 1'b0;
  endtask : setr

  task automatic enter(logic [7:0] ctl);
    wr_reg(`ADDR_MODE, 8'h01);
    wr_reg(`ADDR_CTRL, ctl);
    repeat (2) @(posedge clk);
    #1;
    chk("stopped", stopped, 1'b1);
    chk("main_osc_en", main_osc_en, 1'b0);
    chk("sub_osc_en", sub_osc_en, 1'b1);
    chk("core_clk_en", core_clk_en, 1'b0);
  endtask : enter

  task automatic wake(wake_req_t r, logic [2:0] exp);
    setr(r);
    for (int i = 0; i < 8 && stopped !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    chk("stopped", stopped, 1'b0);
    chk("ack_branch_pend", {7'h00, ack_q, branch_q, pending_q}, {7'h00, exp});
    chk("main_osc_en", main_osc_en, 1'b1);
    chk("core_clk_en", core_clk_en, 1'b0);
  endtask : wake

  task automatic t_reset();
    rd_chk(`ADDR_MODE, 8'h00);
    rd_chk(`ADDR_CTRL, 8'h00);
    rd_chk(`ADDR_CLKSEL, 8'h00);
    rd_chk(`ADDR_CLKSEL_HI, 8'h00);
    rd_chk(4'hf, 8'h00);
    chk("periph_run", periph_run, 10'h3ff);
    $display("test reset done");
  endtask : t_reset

  task automatic t_nmi();
    irq_enabled_state <= 1'b0;
    wr_reg(`ADDR_CLKSEL, 8'hff);
    enter(8'h01);
    chk("periph_run", periph_run, 10'h03f);
    wake('{1'b1, 1'b0, 1'b0, 4'h0}, 3'b110);
    repeat (4) @(posedge clk);
    #1;
    chk("core_clk_en", core_clk_en, 1'b1);
    chk("periph_run", periph_run, 10'h3ff);
    rd_chk(`ADDR_CTRL, 8'h00);
    $display("test nmi done");
  endtask : t_nmi

  task automatic t_mask();
    wr_reg(`ADDR_CLKSEL, 8'h08);
    wr_reg(`ADDR_CLKSEL_HI, 8'h03);
    enter(8'h0f);
    chk("periph_run", periph_run, 10'h0c2);
    setr('{1'b1, 1'b1, 1'b1, 4'h0});
    repeat (6) @(posedge clk);
    #1;
    chk("stopped", stopped, 1'b1);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("stopped", stopped, 1'b0);
    chk("main_osc_en", main_osc_en, 1'b1);
    rd_chk(`ADDR_CLKSEL, 8'h00);
    rd_chk(`ADDR_CLKSEL_HI, 8'h00);
    $display("test mask done");
  endtask : t_mask

  task automatic t_prio();
    in_isr <= 1'b1;
    cur_prio <= 4'h2;
    irq_enabled_state <= 1'b1;
    enter(8'h01);
    wake('{1'b0, 1'b0, 1'b1, 4'h5}, 3'b001);
    setr('0);
    rd_chk(`ADDR_STATUS, 8'h04);
    in_isr <= 1'b0;
    irq_enabled_state <= 1'b0;
    enter(8'h01);
    wake('{1'b0, 1'b0, 1'b1, 4'h5}, 3'b101);
    @(posedge clk);
    #1;
    chk("pending_q", pending_q, 1'b0);
    $display("test priority done");
  endtask : t_prio

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  initial begin
    #(3000 * 100);
    fail_count++;
    finish_test();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_nmi();
    t_mask();
    t_prio();
    finish_test();
  end
endmodule : tb_stop_wakeup_control
